// *** design/cmf_ctrl.sv ***
// Bus-side mode control, diagnostic flags, status pin and register slave.
//
// Overview of operation
// - System off: bus side off, bus pins and receive output floating.
// - Sleep or standby, wake clear: offline, bus to ground, receive high.
// - Offline: no transmit or receive, only low-power receiver watches.
// - Sleep or standby, wake set: wake mode, receive low, bus to ground.
// - Normal or listen with supply low: pass-through, no transmit.
// - Pass-through: low-power receiver result drives the receive output.
// - Normal with supply good: active mode, transmit and receive.
// - Active: no transmission until transmit input seen high once.
// - Active, recessive: bus biased at half supply.
// - Listen with supply good: receive only, bus at half supply.
// - Four flags; mode picks one for the status pin while I/O is up.
// - Status pin low when selected flag set, high when clear.
// - Power-on flag sets when battery recovers from undervoltage.
// - Power-on flag also sets wake and wake-source flags.
// - Power-on shown in listen from standby or sleep; cleared by normal.
// - Wake set by wake-ups or power-on, shown asleep, cleared by normal.
// - Wake-source set by local wake or power-on, shown in normal.
// - Local failure set by four failure events, shown in listen from normal.
// - Local failure cleared by power-on, or by resolution conditions.
// - Supplies filtered by detection and recovery times.
`timescale 1ns/1ps
module cmf_ctrl
   import cmf_pkg::*;
#(
   parameter int DET_CYC = DET_UV_CYC,
   parameter int REC_CYC = REC_UV_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // System side.
   input wire logic [2:0] sys_mode,
   input wire logic vcc_below,
   input wire logic io_level_supply_below,
   input wire logic vbat_below,
   input wire logic wake_local,
   input wire logic wake_remote,
   input wire logic fail_txd_dom,
   input wire logic fail_txd_rxd_short,
   input wire logic fail_bus_dom,
   input wire logic fail_overtemp,
   // Host pins and bus side.
   input wire logic txd,
   input wire logic rxd_lowpower,
   input wire logic rxd_diff,
   output logic rxd,
   output logic rxd_oe_n,
   output logic err_n,
   output logic err_oe_n,
   output logic tx_dominant,
   output logic [1:0] bus_bias,
   output logic [2:0] can_mode
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      cmf_can_e mode;
      logic [2:0] prev_sys;
      logic from_normal;
      logic vbat_uv_q;
      logic pwon;
      logic wake;
      logic wsrc;
      logic lfail;
      logic lfail_other;
      logic bus_dom_q;
      logic armed;
      logic tx_allow;
      logic dp_wr;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
      logic rxd;
      logic rxd_oe_n;
      logic err_n;
      logic err_oe_n;
      logic tx_dom;
      cmf_bias_e bias;
   } cmf_ctrl_s;

   cmf_ctrl_s s_r;
   cmf_ctrl_s s_nxt;
   logic vcc_uv;
   logic vio_uv;
   logic vbat_uv;
   logic enter_normal;
   logic pwon_set;
   logic any_fail;
   logic other_fail;
   logic sel_flag;
   logic addr_ok;
   logic [31:0] status_word;

   // ****************************************************************
   // Supply filters
   // ****************************************************************
   cmf_uv_filter #(.DET_CYC(DET_CYC), .REC_CYC(REC_CYC)) u_vcc_uv
   (
      .clk(clk),
      .rst(rst),
      .below(vcc_below),
      .uv(vcc_uv)
   );

   cmf_uv_filter #(.DET_CYC(DET_CYC), .REC_CYC(REC_CYC)) u_vio_uv
   (
      .clk(clk),
      .rst(rst),
      .below(io_level_supply_below),
      .uv(vio_uv)
   );

   cmf_uv_filter #(.DET_CYC(DET_CYC), .REC_CYC(REC_CYC)) u_vbat_uv
   (
      .clk(clk),
      .rst(rst),
      .below(vbat_below),
      .uv(vbat_uv)
   );

   // ****************************************************************
   // Event decode
   // ****************************************************************
   // Mode transitions and failure summary used by the flag logic.
   assign enter_normal = (sys_mode == SYS_NORMAL) &&
                         (s_r.prev_sys != SYS_NORMAL);
   assign pwon_set = s_r.vbat_uv_q && !vbat_uv;
   assign other_fail = fail_txd_dom || fail_txd_rxd_short || fail_overtemp;
   assign any_fail = other_fail || fail_bus_dom;

   // Status word read by software.
   always_comb
   begin
      status_word = '0;
      status_word[ST_MODE_LSB +: 3] = s_r.mode;
      status_word[ST_PWON_BIT] = s_r.pwon;
      status_word[ST_WAKE_BIT] = s_r.wake;
      status_word[ST_WSRC_BIT] = s_r.wsrc;
      status_word[ST_LFAIL_BIT] = s_r.lfail;
      status_word[ST_VCC_UV_BIT] = vcc_uv;
      status_word[ST_VIO_UV_BIT] = vio_uv;
      status_word[ST_VBAT_UV_BIT] = vbat_uv;
      status_word[ST_SYS_LSB +: 3] = sys_mode;
   end

   // Flag that the current system mode puts on the status pin.
   always_comb
   begin
      case (sys_mode)
         SYS_STANDBY, SYS_SLEEP: sel_flag = s_r.wake;
         SYS_NORMAL: sel_flag = s_r.wsrc;
         SYS_LISTEN: sel_flag = s_r.from_normal ? s_r.lfail : s_r.pwon;
         default: sel_flag = 1'b0;
      endcase
   end

   assign addr_ok = hsel && htrans[1] && hready;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.prev_sys = sys_mode;
      s_nxt.vbat_uv_q = vbat_uv;
      s_nxt.bus_dom_q = fail_bus_dom;

      // Listen mode remembers which mode led into it.
      if (sys_mode == SYS_LISTEN && s_r.prev_sys != SYS_LISTEN)
      begin
         s_nxt.from_normal = (s_r.prev_sys == SYS_NORMAL);
      end

      // Power-on flag: the set wins over the clear.
      if (enter_normal)
      begin
         s_nxt.pwon = 1'b0;
      end
      if (pwon_set)
      begin
         s_nxt.pwon = 1'b1;
      end

      // Wake flag.
      if (enter_normal)
      begin
         s_nxt.wake = 1'b0;
      end
      if (wake_local || wake_remote || pwon_set)
      begin
         s_nxt.wake = 1'b1;
      end

      // Wake-up source flag: only a local wake-up or power-on names it.
      if (s_r.prev_sys == SYS_NORMAL && sys_mode != SYS_NORMAL)
      begin
         s_nxt.wsrc = 1'b0;
      end
      if (wake_local || pwon_set)
      begin
         s_nxt.wsrc = 1'b1;
      end

      // Local failure flag: clears first, then any live failure sets.
      if (pwon_set)
      begin
         s_nxt.lfail = 1'b0;
         s_nxt.lfail_other = 1'b0;
      end
      else if (!any_fail && s_r.lfail)
      begin
         if (enter_normal || (!s_r.rxd && !s_r.rxd_oe_n && txd) ||
             (s_r.bus_dom_q && !s_r.lfail_other))
         begin
            s_nxt.lfail = 1'b0;
            s_nxt.lfail_other = 1'b0;
         end
      end
      if (any_fail)
      begin
         s_nxt.lfail = 1'b1;
      end
      if (other_fail)
      begin
         s_nxt.lfail_other = 1'b1;
      end

      // Bus-side mode follows its inputs every cycle.
      s_nxt.mode = cmf_mode_of(sys_mode, vcc_uv, s_r.wake);

      // Transmit arming within active mode.
      if (s_nxt.mode != CAN_ACTIVE)
      begin
         s_nxt.armed = 1'b0;
      end
      else if (txd)
      begin
         s_nxt.armed = 1'b1;
      end

      // Bus drive, bias and receive output per mode.
      s_nxt.tx_dom = 1'b0;
      s_nxt.rxd_oe_n = 1'b0;
      s_nxt.rxd = 1'b1;
      s_nxt.bias = BIAS_GND;
      case (s_nxt.mode)
         CAN_OFF:
         begin
            s_nxt.rxd_oe_n = 1'b1;
            s_nxt.bias = BIAS_FLOAT;
         end
         CAN_OFFLINE:
         begin
            s_nxt.rxd = 1'b1;
         end
         CAN_WAKE:
         begin
            s_nxt.rxd = 1'b0;
         end
         CAN_PASS:
         begin
            s_nxt.rxd = rxd_lowpower;
         end
         CAN_ACTIVE:
         begin
            s_nxt.bias = BIAS_HALF;
            s_nxt.rxd = rxd_diff;
            s_nxt.tx_dom = s_r.armed && !txd && s_r.tx_allow &&
                           !s_r.lfail_other;
         end
         CAN_LISTEN:
         begin
            s_nxt.bias = BIAS_HALF;
            s_nxt.rxd = rxd_diff;
         end
         default:
         begin
            s_nxt.rxd_oe_n = 1'b1;
            s_nxt.bias = BIAS_FLOAT;
         end
      endcase

      // Status pin is driven only while the I/O supply is up.
      s_nxt.err_oe_n = vio_uv || (sys_mode == SYS_OFF);
      s_nxt.err_n = !sel_flag;

      // Register bus: address phase captured, write in data phase.
      if (s_r.dp_wr && s_r.dp_addr == CTRL_OFS)
      begin
         s_nxt.tx_allow = hwdata[CTRL_TX_ALLOW_BIT];
      end
      s_nxt.dp_wr = addr_ok && hwrite;
      s_nxt.dp_addr = haddr[7:0];
      if (addr_ok && !hwrite)
      begin
         case (haddr[7:0])
            CTRL_OFS: s_nxt.rdata = {31'h0, s_nxt.tx_allow};
            STATUS_OFS: s_nxt.rdata = status_word;
            default: s_nxt.rdata = 32'h0;
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '{mode: CAN_OFF, prev_sys: SYS_OFF, from_normal: 1'b0,
                  vbat_uv_q: 1'b1, pwon: 1'b0, wake: 1'b0, wsrc: 1'b0,
                  lfail: 1'b0, lfail_other: 1'b0, bus_dom_q: 1'b0,
                  armed: 1'b0, tx_allow: CTRL_TX_ALLOW_RST, dp_wr: 1'b0,
                  dp_addr: 8'h00, rdata: 32'h0, rxd: 1'b1, rxd_oe_n: 1'b1,
                  err_n: 1'b1, err_oe_n: 1'b1, tx_dom: 1'b0,
                  bias: BIAS_FLOAT};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_r.rdata;
   assign rxd = s_r.rxd;
   assign rxd_oe_n = s_r.rxd_oe_n;
   assign err_n = s_r.err_n;
   assign err_oe_n = s_r.err_oe_n;
   assign tx_dominant = s_r.tx_dom;
   assign bus_bias = s_r.bias;
   assign can_mode = s_r.mode;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   off_floats_a: assert property (s_r.mode == CAN_OFF |->
      s_r.rxd_oe_n && s_r.bias == BIAS_FLOAT && !s_r.tx_dom)
      else $error("off mode does not float the pins");
   offline_rxd_a: assert property (s_r.mode == CAN_OFFLINE |->
      s_r.rxd && !s_r.rxd_oe_n && s_r.bias == BIAS_GND && !s_r.tx_dom)
      else $error("offline mode outputs wrong");
   wake_rxd_a: assert property (s_r.mode == CAN_WAKE |->
      !s_r.rxd && s_r.bias == BIAS_GND)
      else $error("wake mode outputs wrong");
   pass_rxd_a: assert property (s_r.mode == CAN_PASS |->
      s_r.rxd == $past(rxd_lowpower) && !s_r.tx_dom)
      else $error("pass-through receive path wrong");
   mode_track_a: assert property (##1 s_r.mode ==
      cmf_mode_of($past(sys_mode), $past(vcc_uv), $past(s_r.wake)))
      else $error("bus mode does not follow its inputs");
   arm_first_a: assert property (s_r.tx_dom |->
      $past(s_r.armed) && s_r.mode == CAN_ACTIVE)
      else $error("transmission before transmit input seen high");
   listen_half_a: assert property (s_r.mode == CAN_LISTEN |->
      s_r.bias == BIAS_HALF && !s_r.tx_dom)
      else $error("listen mode drive or bias wrong");
   err_normal_a: assert property (sys_mode == SYS_NORMAL &&
      $stable(sys_mode) |=> s_r.err_n == !$past(s_r.wsrc))
      else $error("status pin does not show wake source");
   pwon_set_a: assert property ($fell(vbat_uv) |=>
      s_r.pwon && s_r.wake && s_r.wsrc && !s_r.lfail ||
      s_r.pwon && s_r.wake && s_r.wsrc && $past(any_fail))
      else $error("power-on did not set its flags");
   lfail_set_a: assert property (any_fail |=> s_r.lfail)
      else $error("failure event did not set local failure");

   active_cv: cover property (s_r.mode == CAN_ACTIVE ##1 s_r.tx_dom);
   wake_cv: cover property (s_r.mode == CAN_OFFLINE ##1
      s_r.mode == CAN_WAKE);
   lfail_clr_cv: cover property (s_r.lfail ##1 !s_r.lfail);
   pass_cv: cover property (s_r.mode == CAN_PASS);

endmodule // cmf_ctrl

// *** design/cmf_pkg.sv ***
// Constants, types and helpers shared by the CAN mode and flag control block.
package cmf_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_PS = 5000;
   localparam int T_DET_UV_NS = 20;
   localparam int T_REC_UV_NS = 20;
   // Both are least times, so the cycle counts round up.
   localparam int DET_UV_CYC_RAW = (T_DET_UV_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
   localparam int REC_UV_CYC_RAW = (T_REC_UV_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
   localparam int DET_UV_CYC = (DET_UV_CYC_RAW < 1) ? 1 : DET_UV_CYC_RAW;
   localparam int REC_UV_CYC = (REC_UV_CYC_RAW < 1) ? 1 : REC_UV_CYC_RAW;

   // ****************************************************************
   // Register map and fields
   // ****************************************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam int CTRL_TX_ALLOW_BIT = 0;
   localparam logic CTRL_TX_ALLOW_RST = 1'b1;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_PWON_BIT = 3;
   localparam int ST_WAKE_BIT = 4;
   localparam int ST_WSRC_BIT = 5;
   localparam int ST_LFAIL_BIT = 6;
   localparam int ST_VCC_UV_BIT = 7;
   localparam int ST_VIO_UV_BIT = 8;
   localparam int ST_VBAT_UV_BIT = 9;
   localparam int ST_SYS_LSB = 10;

   // ****************************************************************
   // Modes
   // ****************************************************************
   typedef enum logic [2:0] {
      SYS_OFF = 3'h0,
      SYS_STANDBY = 3'h1,
      SYS_NORMAL = 3'h2,
      SYS_LISTEN = 3'h3,
      SYS_SLEEP = 3'h4
   } cmf_sys_e;

   // Gray codes along off, offline, wake, pass-through, active, listen.
   typedef enum logic [2:0] {
      CAN_OFF = 3'h0,
      CAN_OFFLINE = 3'h1,
      CAN_WAKE = 3'h3,
      CAN_PASS = 3'h2,
      CAN_ACTIVE = 3'h6,
      CAN_LISTEN = 3'h7
   } cmf_can_e;

   typedef enum logic [1:0] {
      BIAS_FLOAT = 2'h0,
      BIAS_GND = 2'h1,
      BIAS_HALF = 2'h2
   } cmf_bias_e;

   // Bus-side mode for a given system mode, supply state and wake flag.
   function automatic cmf_can_e cmf_mode_of(input logic [2:0] sys,
                                            input logic vcc_uv,
                                            input logic wake);
      case (sys)
         SYS_STANDBY, SYS_SLEEP: cmf_mode_of = wake ? CAN_WAKE : CAN_OFFLINE;
         SYS_NORMAL: cmf_mode_of = vcc_uv ? CAN_PASS : CAN_ACTIVE;
         SYS_LISTEN: cmf_mode_of = vcc_uv ? CAN_PASS : CAN_LISTEN;
         default: cmf_mode_of = CAN_OFF;
      endcase
   endfunction

endpackage

// *** design/cmf_uv_filter.sv ***
// Supply undervoltage filter with separate detection and recovery times.
`timescale 1ns/1ps
module cmf_uv_filter
   import cmf_pkg::*;
#(
   parameter int DET_CYC = DET_UV_CYC,
   parameter int REC_CYC = REC_UV_CYC,
   parameter int CW = 16
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic below,
   output logic uv
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic uv;
      logic [CW-1:0] cnt;
   } cmf_uvf_s;

   cmf_uvf_s s_r;
   cmf_uvf_s s_nxt;
   logic [CW-1:0] limit;

   // Counts the counter cannot hold are refused when the design is built.
   if (DET_CYC < 1 || REC_CYC < 1 || DET_CYC >= (1 << CW) ||
       REC_CYC >= (1 << CW))
   begin : g_bad_counts
      $error("cmf_uv_filter: cycle counts out of range");
   end

   // The raw level must hold for the whole time before the state flips.
   always_comb
   begin
      s_nxt = s_r;
      limit = s_r.uv ? CW'(REC_CYC) : CW'(DET_CYC);
      if (below != s_r.uv)
      begin
         if (s_r.cnt + CW'(1) >= limit)
         begin
            s_nxt.uv = below;
            s_nxt.cnt = '0;
         end
         else
         begin
            s_nxt.cnt = s_r.cnt + CW'(1);
         end
      end
      else
      begin
         s_nxt.cnt = '0;
      end
   end

   // Supplies count as low out of reset.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '{uv: 1'b1, cnt: '0};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign uv = s_r.uv;

endmodule // cmf_uv_filter

// *** tb/can_mode_and_flag_control_tb.sv ***
// Self-checking bench for the CAN mode and flag control block.
`timescale 1ns/1ps
module can_mode_and_flag_control_tb
   import cmf_pkg::*;
;
   typedef struct {int k; logic [31:0] v;} cmf_note_s;
   localparam int SETTLE = 8;
   localparam int K_MODE = 0, K_RXD = 1, K_BIAS = 2, K_TX = 3;
   localparam int K_ERR = 4, K_EOE = 5, K_ROE = 6, K_RD = 7, K_RSP = 8;
   logic clk, rst, hsel, hwrite, hreadyout, hresp, txd, txd_want, slow;
   logic [31:0] haddr, hwdata, hrdata, rd_val, b;
   logic [31:0] seed = 32'h2F;
   logic [1:0] htrans, bus_bias;
   logic [2:0] hsize, sys_mode, can_mode;
   logic vcc_below, io_level_supply_below, vbat_below, wake_local;
   logic wake_remote, fail_txd_dom, fail_txd_rxd_short, fail_bus_dom;
   logic fail_overtemp, rxd_lowpower, rxd_diff, rxd, rxd_oe_n;
   logic err_n, err_oe_n, tx_dominant;
   int num_errors = 0, n_tests = 0;
   cmf_note_s q[$];
   cmf_note_s nt;

   cmf_ctrl #(.DET_CYC(2), .REC_CYC(2)) dut (.clk(clk), .rst(rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .sys_mode(sys_mode), .vcc_below(vcc_below),
      .io_level_supply_below(io_level_supply_below),
      .vbat_below(vbat_below), .wake_local(wake_local),
      .wake_remote(wake_remote), .fail_txd_dom(fail_txd_dom),
      .fail_txd_rxd_short(fail_txd_rxd_short),
      .fail_bus_dom(fail_bus_dom), .fail_overtemp(fail_overtemp),
      .txd(txd), .rxd_lowpower(rxd_lowpower), .rxd_diff(rxd_diff),
      .rxd(rxd), .rxd_oe_n(rxd_oe_n), .err_n(err_n),
      .err_oe_n(err_oe_n), .tx_dominant(tx_dominant),
      .bus_bias(bus_bias), .can_mode(can_mode));

   cmf_host_model host (.clk(clk), .rst(rst), .txd_want(txd_want),
      .slow(slow), .txd(txd));

   // ****************************************************
   // Helpers
   // ****************************************************
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Status word for a mode pair and the four flags, power-on first.
   function automatic logic [31:0] st(cmf_can_e c, cmf_sys_e s,
                                      logic [3:0] f);
      return 32'(c) | (32'(f) << ST_PWON_BIT) | (32'(s) << ST_SYS_LSB);
   endfunction

   function automatic logic [31:0] pin(input int k);
      case (k)
         K_MODE: return {29'h0, can_mode};
         K_RXD: return {31'h0, rxd};
         K_BIAS: return {30'h0, bus_bias};
         K_TX: return {31'h0, tx_dominant};
         K_ERR: return {31'h0, err_n};
         K_EOE: return {31'h0, err_oe_n};
         K_ROE: return {31'h0, rxd_oe_n};
         K_RSP: return {31'h0, hresp};
         default: return rd_val;
      endcase
   endfunction

   task automatic stop_test(input bit hang);
      if (hang)
         num_errors++;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic e(input int k, input logic [31:0] v);
      q.push_back('{k, v});
   endtask

   task automatic em(cmf_can_e m, cmf_bias_e bi);
      e(K_MODE, 32'(m));
      e(K_BIAS, 32'(bi));
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic go(cmf_sys_e s);
      sys_mode <= s;
      step(SETTLE);
   endtask

   // Waits for the slave to be ready, a bounded number of edges.
   task automatic wait_rdy();
      int i;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (hreadyout === 1'b1)
            break;
      end
      if (i == 20)
         stop_test(1);
   endtask

   // One single word transfer: address phase, then data phase.
   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd_val = hrdata;
      // Every transfer must end with an OKAY response.
      e(K_RSP, 32'h0);
   endtask

   task automatic rand_rx(input bit low_power);
      for (int i = 0; i < 4; i++)
      begin
         b = xs();
         if (low_power)
            rxd_lowpower <= b[0];
         else
            rxd_diff <= b[0];
         step(2);
         e(K_RXD, {31'h0, b[0]});
      end
   endtask

   // ****************************************************
   // Clock, monitor and watchdog
   // ****************************************************
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Each pending note is compared with the pins once they have settled.
   always @(negedge clk)
      while (q.size() != 0)
      begin
         nt = q.pop_front();
         check(pin(nt.k), nt.v);
      end

   initial
   begin
      repeat (20000) @(posedge clk);
      stop_test(1);
   end

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial
   begin
      {rst, hsel, htrans, haddr, hwrite, hwdata} = {1'b1, 68'h0};
      {hsize, sys_mode, txd_want, slow} = {3'h2, 3'h0, 2'h0};
      {vcc_below, io_level_supply_below, vbat_below} = 3'h0;
      {wake_local, wake_remote, fail_txd_dom} = 3'h0;
      {fail_txd_rxd_short, fail_bus_dom, fail_overtemp} = 3'h0;
      {rxd_lowpower, rxd_diff} = 2'h3;
      step(6);
      rst <= 1'b0;
      step(SETTLE);
      em(CAN_OFF, BIAS_FLOAT);
      e(K_ROE, 32'h1);
      e(K_EOE, 32'h1);
      go(SYS_STANDBY);
      em(CAN_WAKE, BIAS_GND);
      e(K_RXD, 32'h0);
      e(K_ROE, 32'h0);
      e(K_ERR, 32'h0);
      go(SYS_LISTEN);
      em(CAN_LISTEN, BIAS_HALF);
      e(K_ERR, 32'h0);
      e(K_TX, 32'h0);
      rand_rx(0);
      bus(0, 32'(STATUS_OFS), 32'h0);
      e(K_RD, st(CAN_LISTEN, SYS_LISTEN, 4'h7));
      go(SYS_NORMAL);
      em(CAN_ACTIVE, BIAS_HALF);
      e(K_TX, 32'h0);
      e(K_ERR, 32'h0);
      e(K_RXD, {31'h0, rxd_diff});
      txd_want <= 1'b1;
      step(SETTLE);
      txd_want <= 1'b0;
      step(SETTLE);
      e(K_TX, 32'h1);
      bus(0, 32'(STATUS_OFS), 32'h0);
      e(K_RD, st(CAN_ACTIVE, SYS_NORMAL, 4'h4));
      // Software transmit permission and an unmapped word.
      slow <= 1'b1;
      bus(0, 32'(CTRL_OFS), 32'h0);
      e(K_RD, 32'h1);
      bus(1, 32'(CTRL_OFS), 32'h0);
      step(SETTLE);
      e(K_TX, 32'h0);
      bus(1, 32'(CTRL_OFS), 32'h1);
      step(SETTLE);
      e(K_TX, 32'h1);
      bus(0, 32'h10, 32'h0);
      e(K_RD, 32'h0);
      // Local failure set and cleared while listening after normal.
      txd_want <= 1'b1;
      rxd_diff <= 1'b1;
      go(SYS_LISTEN);
      e(K_ERR, 32'h1);
      fail_bus_dom <= 1'b1;
      step(SETTLE);
      e(K_ERR, 32'h0);
      fail_bus_dom <= 1'b0;
      step(SETTLE);
      e(K_ERR, 32'h1);
      fail_overtemp <= 1'b1;
      step(SETTLE);
      fail_overtemp <= 1'b0;
      step(SETTLE);
      e(K_ERR, 32'h0);
      rxd_diff <= 1'b0;
      step(SETTLE);
      e(K_ERR, 32'h1);
      rxd_diff <= 1'b1;
      go(SYS_NORMAL);
      e(K_ERR, 32'h1);
      // Transceiver supply low gives pass-through in both modes.
      vcc_below <= 1'b1;
      txd_want <= 1'b0;
      step(SETTLE);
      em(CAN_PASS, BIAS_GND);
      e(K_TX, 32'h0);
      rand_rx(1);
      go(SYS_LISTEN);
      em(CAN_PASS, BIAS_GND);
      vcc_below <= 1'b0;
      go(SYS_SLEEP);
      em(CAN_OFFLINE, BIAS_GND);
      e(K_RXD, 32'h1);
      e(K_ERR, 32'h1);
      {rxd_diff, rxd_lowpower} <= 2'h0;
      step(2);
      e(K_RXD, 32'h1);
      e(K_TX, 32'h0);
      wake_remote <= 1'b1;
      step(1);
      wake_remote <= 1'b0;
      step(SETTLE);
      em(CAN_WAKE, BIAS_GND);
      e(K_RXD, 32'h0);
      e(K_ERR, 32'h0);
      go(SYS_NORMAL);
      e(K_ERR, 32'h1);
      go(SYS_SLEEP);
      wake_local <= 1'b1;
      step(1);
      wake_local <= 1'b0;
      go(SYS_NORMAL);
      e(K_ERR, 32'h0);
      io_level_supply_below <= 1'b1;
      step(SETTLE);
      e(K_EOE, 32'h1);
      io_level_supply_below <= 1'b0;
      step(SETTLE);
      e(K_EOE, 32'h0);
      // A battery drop and recovery while a local failure is pending.
      rxd_diff <= 1'b1;
      go(SYS_LISTEN);
      fail_txd_dom <= 1'b1;
      step(2);
      fail_txd_dom <= 1'b0;
      step(SETTLE);
      e(K_ERR, 32'h0);
      vbat_below <= 1'b1;
      step(SETTLE);
      vbat_below <= 1'b0;
      step(SETTLE);
      e(K_ERR, 32'h1);
      go(SYS_STANDBY);
      e(K_ERR, 32'h0);
      bus(0, 32'(STATUS_OFS), 32'h0);
      e(K_RD, st(CAN_WAKE, SYS_STANDBY, 4'h7));
      step(2);
      stop_test(0);
   end
endmodule // can_mode_and_flag_control_tb

// *** tb/cmf_host_model.sv ***
// Host controller model that drives the transmit input of the block.
`timescale 1ns/1ps
module cmf_host_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic txd_want,
   input wire logic slow,
   output logic txd
);
   logic stage_r;

   // Bits leave one edge late, or two when the host is slow.
   // The line idles recessive out of reset, as a real controller does.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stage_r <= 1'b1;
         txd <= 1'b1;
      end
      else
      begin
         stage_r <= txd_want;
         txd <= slow ? stage_r : txd_want;
      end
   end
endmodule // cmf_host_model
